//--- verilog/rdc_pkg.sv
// Constants, register map and carrier types of the remote diode compensation and filter block.
// Assumes a register port driven by the serial interface and a conversion sequencer
// and analog front end that run on the same clock.
package rdc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_TEMP_R1_MSB = 8'h02;
  localparam logic [7:0] ADDR_TEMP_R1_LSB = 8'h03;
  localparam logic [7:0] ADDR_TEMP_R2_MSB = 8'h04;
  localparam logic [7:0] ADDR_TEMP_R2_LSB = 8'h05;
  localparam logic [7:0] ADDR_TEMP_R3_MSB = 8'h06;
  localparam logic [7:0] ADDR_TEMP_R3_LSB = 8'h07;
  localparam logic [7:0] ADDR_IDEAL_FACTOR = 8'h14;
  localparam logic [7:0] ADDR_IDEAL_EN = 8'h15;
  localparam logic [7:0] ADDR_FILTER_EN = 8'h18;
  localparam logic [7:0] ADDR_BETA_EN = 8'h19;
  localparam logic [7:0] ADDR_BETA_R1 = 8'h1a;
  localparam logic [7:0] ADDR_BETA_R2 = 8'h1b;
  localparam logic [7:0] ADDR_BETA_R3 = 8'h1c;
  localparam logic [7:0] ADDR_DIODE_FAULT = 8'h36;
  // Per-channel enable field sits in bits 3:1
  localparam int CH_FIELD_LSB = 1;
  localparam int CH_FIELD_MSB = 3;
  // Reset values
  localparam logic [7:0] RST_IDEAL_FACTOR = 8'h18;
  localparam logic [2:0] RST_CH_ENABLES = 3'h0;
  localparam logic [3:0] RST_BETA_CODE = 4'h0;
  localparam logic [15:0] RST_TEMP = 16'h0000;
  localparam logic [3:0] RST_DRIVE_LEVEL = 4'h0;
  // Fixed default ideality selection code (1.008)
  localparam logic [7:0] DEFAULT_IDEALITY_CODE = 8'h18;
  // Beta code reporting a low-beta fault
  localparam logic [3:0] BETA_FAULT_CODE = 4'hf;
  // Temperature written on any diode fault
  localparam logic [15:0] FAULT_TEMP = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BETA = 2'b01,
    ST_MEAS = 2'b11
  } rdc_state_e;

  // Register access from the serial interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rdc_reg_req_s;

  // Settings frozen for the conversion in progress
  typedef struct packed {
    logic [1:0] ch;
    logic [7:0] ideality;
    logic beta_en;
  } rdc_conv_s;

  // Measurement result from the front end
  typedef struct packed {
    logic fault;
    logic [15:0] temp;
  } rdc_meas_s;
endpackage

//--- verilog/rdc_avg4.sv
// Four-sample running average per remote channel.
// Assumes push and channel come from the same clock; channel is 1 to 3.
`timescale 1ns/1ns
`default_nettype none
module rdc_avg4 (
  input wire logic clk_in, // Device clock
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic push_in, // Store sample into history
  input wire logic [1:0] ch_in, // Channel of the sample
  input wire logic [15:0] sample_in, // New conversion result
  output logic [15:0] avg_out // Mean of sample and last three
);
  import rdc_pkg::*;

  // Three most recent samples of each channel
  logic [3:1][2:0][15:0] hist;
  logic [17:0] sum;

  // Sign-extended sum of the new sample and the three before it
  assign sum = {{2{sample_in[15]}}, sample_in} +
               {{2{hist[ch_in][0][15]}}, hist[ch_in][0]} +
               {{2{hist[ch_in][1][15]}}, hist[ch_in][1]} +
               {{2{hist[ch_in][2][15]}}, hist[ch_in][2]};
  assign avg_out = sum[17:2];

  // History is cleared only by reset, so one-shot sequences average across idle gaps
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hist <= '0;
    end else if (push_in && ch_in != 2'h0) begin
      hist[ch_in] <= {hist[ch_in][1:0], sample_in};
    end
  end
endmodule
`default_nettype wire

//--- verilog/rdc_comp_filter.sv
// Remote diode compensation control: ideality select, beta compensation, low-beta fault,
// diode fault status and the four-conversion averaging filter for remote channels 1 to 3.
// Assumes the serial interface drives the register port and a sequencer and front end on
// the same clock start conversions and return beta and temperature results as pulses.
`timescale 1ns/1ns
`default_nettype none
module rdc_comp_filter (
  input wire logic clk_in, // Device clock, 25 MHz
  input wire logic rst_in, // Asynchronous reset, active high
  input wire rdc_pkg::rdc_reg_req_s reg_req_in, // Register read or write request
  output logic [7:0] reg_rdata_out, // Read data, valid the cycle after rd
  input wire logic conv_start_in, // Start a remote conversion, pulse
  input wire logic [1:0] conv_ch_in, // Channel to convert, 1 to 3
  input wire logic beta_done_in, // Beta measurement finished, pulse
  input wire logic [3:0] beta_code_in, // Minimum beta code from front end
  input wire logic meas_done_in, // Temperature measurement finished, pulse
  input wire rdc_pkg::rdc_meas_s meas_in, // Temperature result and diode fault
  output rdc_pkg::rdc_conv_s conv_cfg_out, // Settings of running conversion
  output logic beta_go_out, // Start beta measurement, pulse
  output logic meas_go_out, // Start temperature measurement, pulse
  output logic [3:0] drive_level_out, // Drive current level for measurement
  output logic busy_out, // Conversion in progress
  output logic [3:1] diode_fault_out // Diode fault flags per channel
);
  import rdc_pkg::*;

  // Registers
  rdc_state_e state;
  logic [7:0] ideal_factor;
  logic [3:1] ideal_en;
  logic [3:1] filt_en;
  logic [3:1] beta_en;
  logic [3:1][3:0] beta_res;
  logic [3:1][15:0] temp;
  logic [3:1] fault;

  // Decoded strobes
  wire start_ok = conv_start_in && state == ST_IDLE && conv_ch_in != 2'h0;
  wire beta_ok = beta_done_in && state == ST_BETA;
  wire meas_ok = meas_done_in && state == ST_MEAS;
  wire low_beta = beta_ok && beta_code_in == BETA_FAULT_CODE;
  wire [1:0] ch = conv_cfg_out.ch;
  wire wr_ideal_factor = reg_req_in.wr && reg_req_in.addr == ADDR_IDEAL_FACTOR;
  wire wr_ideal_en = reg_req_in.wr && reg_req_in.addr == ADDR_IDEAL_EN;
  wire wr_filt_en = reg_req_in.wr && reg_req_in.addr == ADDR_FILTER_EN;
  wire wr_beta_en = reg_req_in.wr && reg_req_in.addr == ADDR_BETA_EN;
  wire [2:0] wr_field = reg_req_in.wdata[CH_FIELD_MSB:CH_FIELD_LSB];

  // Ideality picked when the conversion starts, so later writes wait for the next one
  wire [7:0] next_ideality = ideal_en[conv_ch_in] ? ideal_factor : DEFAULT_IDEALITY_CODE;

  // Averaging path
  wire [15:0] avg;
  wire store_ok = meas_ok && !meas_in.fault;
  wire [15:0] next_temp = filt_en[ch] ? avg : meas_in.temp;

  rdc_avg4 u_avg4 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .push_in(store_ok),
    .ch_in(ch),
    .sample_in(meas_in.temp),
    .avg_out(avg)
  );

  // Pads a per-channel field into bits 3:1 with reserved bits zero
  function automatic logic [7:0] ch_byte(input logic [3:1] f);
    ch_byte = {4'h0, f, 1'b0};
  endfunction

  // Read decode
  wire [7:0] rd_data =
    (reg_req_in.addr == ADDR_TEMP_R1_MSB) ? temp[1][15:8] :
    (reg_req_in.addr == ADDR_TEMP_R1_LSB) ? temp[1][7:0] :
    (reg_req_in.addr == ADDR_TEMP_R2_MSB) ? temp[2][15:8] :
    (reg_req_in.addr == ADDR_TEMP_R2_LSB) ? temp[2][7:0] :
    (reg_req_in.addr == ADDR_TEMP_R3_MSB) ? temp[3][15:8] :
    (reg_req_in.addr == ADDR_TEMP_R3_LSB) ? temp[3][7:0] :
    (reg_req_in.addr == ADDR_IDEAL_FACTOR) ? ideal_factor :
    (reg_req_in.addr == ADDR_IDEAL_EN) ? ch_byte(ideal_en) :
    (reg_req_in.addr == ADDR_FILTER_EN) ? ch_byte(filt_en) :
    (reg_req_in.addr == ADDR_BETA_EN) ? ch_byte(beta_en) :
    (reg_req_in.addr == ADDR_BETA_R1) ? {4'h0, beta_res[1]} :
    (reg_req_in.addr == ADDR_BETA_R2) ? {4'h0, beta_res[2]} :
    (reg_req_in.addr == ADDR_BETA_R3) ? {4'h0, beta_res[3]} :
    (reg_req_in.addr == ADDR_DIODE_FAULT) ? ch_byte(fault) :
    8'h00;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= rd_data;
    end
  end

  // Writable registers; the enable registers keep only bits 3:1, ideal_factor keeps all eight bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ideal_factor <= RST_IDEAL_FACTOR;
      ideal_en <= RST_CH_ENABLES;
      filt_en <= RST_CH_ENABLES;
      beta_en <= RST_CH_ENABLES;
    end else begin
      if (wr_ideal_factor) begin
        ideal_factor <= reg_req_in.wdata;
      end
      if (wr_ideal_en) begin
        ideal_en <= wr_field;
      end
      if (wr_filt_en) begin
        filt_en <= wr_field;
      end
      if (wr_beta_en) begin
        beta_en <= wr_field;
      end
    end
  end

  // Conversion sequence: settings frozen at start, beta first when enabled
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      conv_cfg_out <= '0;
      beta_go_out <= 1'b0;
      meas_go_out <= 1'b0;
      drive_level_out <= RST_DRIVE_LEVEL;
    end else begin
      beta_go_out <= 1'b0;
      meas_go_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            conv_cfg_out.ch <= conv_ch_in;
            conv_cfg_out.ideality <= next_ideality;
            conv_cfg_out.beta_en <= beta_en[conv_ch_in];
            if (beta_en[conv_ch_in]) begin
              state <= ST_BETA;
              beta_go_out <= 1'b1;
            end else begin
              state <= ST_MEAS;
              drive_level_out <= RST_DRIVE_LEVEL;
              meas_go_out <= 1'b1;
            end
          end
        end
        ST_BETA: begin
          if (low_beta) begin
            state <= ST_IDLE;
          end else if (beta_ok) begin
            state <= ST_MEAS;
            drive_level_out <= beta_code_in;
            meas_go_out <= 1'b1;
          end
        end
        ST_MEAS: begin
          if (meas_ok) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Beta results, temperatures and fault flags change only when a step completes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      beta_res <= {3{RST_BETA_CODE}};
      temp <= {3{RST_TEMP}};
      fault <= RST_CH_ENABLES;
    end else if (low_beta) begin
      beta_res[ch] <= beta_code_in;
      temp[ch] <= FAULT_TEMP;
      fault[ch] <= 1'b1;
    end else if (beta_ok) begin
      beta_res[ch] <= beta_code_in;
    end else if (meas_ok) begin
      temp[ch] <= meas_in.fault ? FAULT_TEMP : next_temp;
      fault[ch] <= meas_in.fault;
    end
  end

  // Status outputs from flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      diode_fault_out <= RST_CH_ENABLES;
    end else begin
      busy_out <= (state != ST_IDLE) || start_ok;
      diode_fault_out <= fault;
    end
  end

  // Checks
  ideal_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
    start_ok |=> conv_cfg_out.ideality ==
      ($past(ideal_en[conv_ch_in]) ? $past(ideal_factor) : DEFAULT_IDEALITY_CODE))
    else $error("ideality selection wrong at conversion start");

  beta_en_map_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_beta_en |=> ch_byte(beta_en) == {4'h0, $past(reg_req_in.wdata[3:1]), 1'b0})
    else $error("beta enable bits not stored in bits 3 to 1");

  cfg_frozen_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state != ST_IDLE) |=> $stable(conv_cfg_out))
    else $error("conversion settings changed while running");

  beta_first_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (start_ok && beta_en[conv_ch_in]) |=> beta_go_out && !meas_go_out ##0
      (!meas_go_out throughout (state == ST_BETA)[*1]))
    else $error("temperature started before beta measurement");

  beta_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
    beta_ok |=> beta_res[$past(ch)] == $past(beta_code_in))
    else $error("beta result not captured");

  beta_rsvd_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr >= ADDR_BETA_R1 && reg_req_in.addr <= ADDR_BETA_R3)
      |=> reg_rdata_out[7:4] == 4'h0)
    else $error("beta result reserved bits not zero");

  low_beta_a: assert property (@(posedge clk_in) disable iff (rst_in)
    low_beta |=> temp[$past(ch)] == FAULT_TEMP && fault[$past(ch)] &&
      state == ST_IDLE && !meas_go_out)
    else $error("low beta did not skip and flag the channel");

  filter_avg_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (store_ok && filt_en[ch]) |=> temp[$past(ch)] == $past(avg))
    else $error("filtered result is not the four-sample mean");

  filter_raw_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (store_ok && !filt_en[ch]) |=> temp[$past(ch)] == $past(meas_in.temp))
    else $error("unfiltered result altered");

  temp_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(meas_ok || low_beta) |=> $stable(temp))
    else $error("temperature changed without a completed conversion");

  fault_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
    low_beta |=> ##1 diode_fault_out[$past(ch, 2)])
    else $error("low beta fault not reported");

  rsvd_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_req_in.rd && (reg_req_in.addr == ADDR_FILTER_EN || reg_req_in.addr == ADDR_IDEAL_EN))
      |=> reg_rdata_out[7:4] == 4'h0 && !reg_rdata_out[0])
    else $error("reserved enable bits read nonzero");
endmodule
`default_nettype wire

//--- verification/rdc_front_model.sv
// Behavioural analog front end: answers beta and temperature starts after a delay.
// Assumes go pulses from the block on the same clock; reported values come from the bench.
`timescale 1ns/1ns
`default_nettype none
module rdc_front_model (
  input wire logic clk_in, // Device clock
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic beta_go_in, // Start beta measurement
  input wire logic meas_go_in, // Start temperature measurement
  input wire logic [7:0] delay_in, // Answer delay in cycles
  input wire logic [3:0] code_in, // Beta code to report
  input wire rdc_pkg::rdc_meas_s result_in, // Result to report
  output logic beta_done_out, // Beta finished, pulse
  output logic [3:0] beta_code_out, // Beta code
  output logic meas_done_out, // Temperature finished, pulse
  output rdc_pkg::rdc_meas_s meas_out // Temperature and fault
);
  import rdc_pkg::*;
  logic [7:0] beta_cnt;
  logic [7:0] meas_cnt;
  logic beta_run;
  logic meas_run;
  // Data lines invert outside a done pulse so a stale value never looks valid
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      beta_run <= 1'b0;
      meas_run <= 1'b0;
      beta_done_out <= 1'b0;
      meas_done_out <= 1'b0;
      beta_code_out <= 4'h0;
      meas_out <= '0;
    end else begin
      beta_done_out <= 1'b0;
      meas_done_out <= 1'b0;
      beta_code_out <= ~beta_code_out;
      meas_out <= ~meas_out;
      beta_cnt <= beta_cnt - 8'h01;
      meas_cnt <= meas_cnt - 8'h01;
      if (beta_go_in) begin
        beta_run <= 1'b1;
        beta_cnt <= delay_in;
      end else if (beta_run && beta_cnt == 8'h00) begin
        beta_run <= 1'b0;
        beta_done_out <= 1'b1;
        beta_code_out <= code_in;
      end
      if (meas_go_in) begin
        meas_run <= 1'b1;
        meas_cnt <= delay_in;
      end else if (meas_run && meas_cnt == 8'h00) begin
        meas_run <= 1'b0;
        meas_done_out <= 1'b1;
        meas_out <= result_in;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/rdc_comp_filter_bench.sv
// Self-checking bench for the compensation and filter block, register port tasks.
// Assumes the front end model answers go pulses; all stimulus is set up here.
`timescale 1ns/1ns
`default_nettype none
module rdc_comp_filter_bench;
  import rdc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  rdc_reg_req_s req = '0;
  logic [7:0] rdata;
  logic start = 1'b0;
  logic [1:0] ch = 2'h0;
  logic beta_done, meas_done, beta_go, meas_go, busy;
  logic [3:0] bcode, drive;
  logic [3:1] dfault;
  rdc_meas_s meas, res = '0;
  rdc_conv_s cfg;
  logic [7:0] dly = 8'h05;
  logic [3:0] code = 4'h3;
  int err_total = 0;
  int tests_run = 0;
  int n_beta = 0;
  int n_meas = 0;
  logic [15:0] avg_exp [3] = '{16'h00c0, 16'h0180, 16'h0280};
  logic [7:0] rst_addr [9] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h36, 8'h02};

  rdc_comp_filter dut_u (.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .conv_start_in(start), .conv_ch_in(ch),
    .beta_done_in(beta_done), .beta_code_in(bcode), .meas_done_in(meas_done),
    .meas_in(meas), .conv_cfg_out(cfg), .beta_go_out(beta_go), .meas_go_out(meas_go),
    .drive_level_out(drive), .busy_out(busy), .diode_fault_out(dfault));
  rdc_front_model fe_u (.clk_in(clk_in), .rst_in(rst_in), .beta_go_in(beta_go),
    .meas_go_in(meas_go), .delay_in(dly), .code_in(code), .result_in(res),
    .beta_done_out(beta_done), .beta_code_out(bcode), .meas_done_out(meas_done),
    .meas_out(meas));

  // 25 MHz clock
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // Count start pulses to see which steps a conversion took
  always @(posedge clk_in) begin
    if (beta_go === 1'b1) n_beta++;
    if (meas_go === 1'b1) n_meas++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in) req <= '0;
    @(posedge clk_in) #1 check({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic temp(input logic [1:0] c, input logic [15:0] exp);
    rd(8'h02 + {5'h00, c - 2'h1, 1'b0}, exp[15:8]);
    rd(8'h03 + {5'h00, c - 2'h1, 1'b0}, exp[7:0]);
  endtask
  // Start one conversion and wait for busy to drop, bounded
  task automatic conv(input logic [1:0] c);
    int i;
    @(posedge clk_in) begin
      start <= 1'b1;
      ch <= c;
    end
    @(posedge clk_in) start <= 1'b0;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_in) #1;
      if (busy === 1'b0) break;
    end
    if (i == 300) begin
      err_total++;
      results();
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    // Reset values of the control, beta result and fault registers and the channel 1 temperature MSB
    foreach (rst_addr[k])
      rd(rst_addr[k], rst_addr[k] == 8'h14 ? RST_IDEAL_FACTOR : 8'h00);
    // Reserved bits dropped, read-only and unmapped places ignore writes
    wr(ADDR_BETA_EN, 8'hff);
    rd(ADDR_BETA_EN, 8'h0e);
    wr(ADDR_IDEAL_EN, 8'hf3);
    rd(ADDR_IDEAL_EN, 8'h02);
    wr(ADDR_FILTER_EN, 8'hff);
    rd(ADDR_FILTER_EN, 8'h0e);
    wr(ADDR_FILTER_EN, 8'h00);
    wr(ADDR_BETA_R1, 8'hff);
    rd(ADDR_BETA_R1, 8'h00);
    wr(8'h55, 8'h7e);
    rd(8'h55, 8'h00);
    // Custom factor on channel 1, default on channel 2
    wr(ADDR_IDEAL_FACTOR, 8'h20);
    wr(ADDR_BETA_EN, 8'h02);
    res <= '{1'b0, 16'h1230};
    conv(2'h1);
    check({8'h00, cfg.ideality}, 16'h0020);
    check({15'h0, cfg.beta_en}, 16'h0001);
    check(16'(n_beta), 16'h0001);
    check({12'h0, drive}, 16'h0003);
    rd(ADDR_BETA_R1, 8'h03);
    temp(2'h1, 16'h1230);
    conv(2'h2);
    check({8'h00, cfg.ideality}, {8'h00, DEFAULT_IDEALITY_CODE});
    check({15'h0, cfg.beta_en}, 16'h0000);
    check({14'h0, cfg.ch}, 16'h0002);
    check({12'h0, drive}, {12'h0, RST_DRIVE_LEVEL});
    // Low beta: no measurement, zero result, fault flagged
    code <= BETA_FAULT_CODE;
    conv(2'h1);
    check(16'(n_meas), 16'h0002);
    temp(2'h1, FAULT_TEMP);
    rd(ADDR_BETA_R1, 8'h0f);
    rd(ADDR_DIODE_FAULT, 8'h02);
    check({13'h0, dfault}, 16'h0001);
    // Enable write mid-conversion leaves that conversion alone
    code <= 4'h9;
    dly <= 8'h14;
    fork
      conv(2'h1);
      begin
        repeat (4) @(posedge clk_in);
        wr(ADDR_BETA_EN, 8'h00);
      end
    join
    check(16'(n_beta), 16'h0003);
    rd(ADDR_BETA_R1, 8'h09);
    temp(2'h2, 16'h1230);
    res <= '{1'b0, 16'h0450};
    conv(2'h1);
    check(16'(n_beta), 16'h0003);
    temp(2'h1, 16'h0450);
    rd(ADDR_DIODE_FAULT, 8'h00);
    // Filter on channel 3, with a long one-shot gap before the last sample
    res <= '{1'b0, 16'h0100};
    conv(2'h3);
    check({8'h00, cfg.ideality}, {8'h00, DEFAULT_IDEALITY_CODE});
    wr(ADDR_FILTER_EN, 8'h08);
    wr(ADDR_IDEAL_EN, 8'h08);
    temp(2'h3, 16'h0100);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) repeat (2000) @(posedge clk_in);
      res <= '{1'b0, 16'h0200 + 16'(k) * 16'h0100};
      conv(2'h3);
      check({8'h00, cfg.ideality}, 16'h0020);
      temp(2'h3, avg_exp[k]);
    end
    // Front end diode fault: zero result, flag set, sample kept out of the history
    res <= '{1'b1, 16'h0777};
    conv(2'h3);
    temp(2'h3, FAULT_TEMP);
    rd(ADDR_DIODE_FAULT, 8'h08);
    check({13'h0, dfault}, 16'h0004);
    res <= '{1'b0, 16'h0500};
    conv(2'h3);
    temp(2'h3, 16'h0380);
    rd(ADDR_DIODE_FAULT, 8'h00);
    results();
  end
endmodule
`default_nettype wire
